// ---- verilog/hsp_pkg.sv ----
`default_nettype none
package hsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_MHZ          = 50;
  localparam int STRAP_SETTLE_US  = 20;
  localparam int STRAP_SETTLE_CYC = STRAP_SETTLE_US * CLK_MHZ;
  localparam int STRAP_SAMPLE_CYC = 16;
  localparam int OUT_DELAY_MS     = 50;
  localparam int OUT_DELAY_MAX_MS = 60;
  localparam int OUT_DELAY_CYC    = OUT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W          = 22;

  ////////////////////////////////////////////////////////////////////////////
  // ports and synchroniser lanes
  localparam int NUM_PORTS = 4;
  localparam int SYNC_W    = 9;
  localparam int LANE_RST  = 0;
  localparam int LANE_PSS  = 1;
  localparam int LANE_GANG = 2;
  localparam int LANE_SCL  = 3;
  localparam int LANE_SDA  = 4;
  localparam int LANE_OC   = 5;
  // power select lane idles at bus powered, the rest at their pull-up level
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 9'h1FD;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_LINE     = 12'h010;

  // control fields
  localparam int CTRL_W          = 5;
  localparam int CTRL_POWER_ON   = 0;
  localparam int CTRL_SUSPEND    = 1;
  localparam int CTRL_EEPROM     = 2;
  localparam int CTRL_SCL_LOW    = 3;
  localparam int CTRL_SDA_LOW    = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // status fields
  localparam int ST_SELF_POWERED = 0;
  localparam int ST_GANG_MODE    = 1;
  localparam int ST_TEST_MODE    = 2;
  localparam int ST_STRAPS_DONE  = 3;
  localparam int ST_PIN_OUTPUT   = 4;
  localparam int ST_OC_LSB       = 8;

  // interrupt fields: overcurrent onset per port, power source change
  localparam int IRQ_W       = 5;
  localparam int IRQ_PSS_CHG = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

endpackage
`default_nettype wire

// ---- verilog/hsp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsp_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // hsp_sync
`default_nettype wire

// ---- verilog/hsp_pin_logic.sv ----
// How it works
// - while the external reset pin is low, all logic returns to its power-up state.
// - power source select reads 0 as bus powered, 1 as self powered.
// - after reset the switching-mode pin stays an input so its strap can be read.
// - strap 1 (ganged): pin later drives 0 in normal operation, 1 in suspend.
// - strap 0 (individual): pin later drives 1 in normal operation, 0 in suspend.
// - test strap on the clock pin: 0 is normal operation, 1 is test mode.
// - the power-switch enable is active low; low switches port power on.
// - with an EEPROM present the shared pin stays serial data, never power enable.
// - each port's overcurrent input is active low and flags that port only.
// - the test strap pin serves as two-wire EEPROM clock for configuration reads.
// - the switching-mode strap is sampled and settled within 20 us after reset.
// - 50 to 60 ms after reset the pin becomes an output showing the suspend flag.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hsp_pin_logic
  import hsp_pkg::*;
#(
  parameter int OUT_DELAY = hsp_pkg::OUT_DELAY_CYC
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [hsp_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic      [31:0]                   prdata,
  output logic                               pslverr,
  input  wire logic                          ext_reset_low,
  input  wire logic                          power_source_select,
  input  wire logic                          gang_in,
  output logic                               gang_out,
  output logic                               gang_oe,
  input  wire logic                          scl_in,
  output logic                               scl_out,
  output logic                               scl_oe,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  input  wire logic [hsp_pkg::NUM_PORTS-1:0] port_overcurrent_low,
  output logic                               self_powered,
  output logic                               test_mode,
  output logic                               irq
);

  import hsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [SYNC_W-1:0]    raw_in;
  logic [SYNC_W-1:0]    sync_in;
  logic                 soft_rst;
  logic                 pss_s;
  logic                 gang_s;
  logic                 scl_s;
  logic                 sda_s;
  logic [NUM_PORTS-1:0] oc_s;

  assign raw_in = {port_overcurrent_low, sda_in, scl_in, gang_in,
                   power_source_select, ext_reset_low};

  hsp_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST_VAL)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign soft_rst = ~sync_in[LANE_RST];
  assign pss_s    = sync_in[LANE_PSS];
  assign gang_s   = sync_in[LANE_GANG];
  assign scl_s    = sync_in[LANE_SCL];
  assign sda_s    = sync_in[LANE_SDA];
  assign oc_s     = sync_in[LANE_OC +: NUM_PORTS];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic              access;
  logic              wr_en;
  logic              rd_en;
  logic              addr_hit;
  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;

  assign access   = psel & penable & ~pready;
  assign wr_en    = access & pwrite;
  assign rd_en    = access & ~pwrite;
  assign addr_hit = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                    (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK) ||
                    (paddr == OFS_LINE);

  ////////////////////////////////////////////////////////////////////////////
  // strap sampling and output timer
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic               straps_done;
  logic               next_straps_done;
  logic               gang_mode;
  logic               next_gang_mode;
  logic               next_test_mode;
  logic               pin_output;
  logic               next_pin_output;
  logic               next_self_powered;
  logic               pss_prev;
  logic               next_pss_prev;
  logic [NUM_PORTS-1:0] oc_prev;
  logic [NUM_PORTS-1:0] next_oc_prev;

  always_comb begin
    next_timer        = timer;
    next_straps_done  = straps_done;
    next_gang_mode    = gang_mode;
    next_test_mode    = test_mode;
    next_pin_output   = pin_output;
    next_self_powered = pss_s;
    next_pss_prev     = pss_s;
    next_oc_prev      = oc_s;
    if (!pin_output) begin
      next_timer = timer + 1'b1;
    end
    if (!straps_done && timer == TIMER_W'(STRAP_SAMPLE_CYC)) begin
      next_gang_mode   = gang_s;
      next_test_mode   = scl_s;
      next_straps_done = 1'b1;
    end
    if (timer == TIMER_W'(OUT_DELAY - 1)) begin
      next_pin_output = 1'b1;
    end
    if (soft_rst) begin
      next_timer        = '0;
      next_straps_done  = 1'b0;
      next_gang_mode    = 1'b0;
      next_test_mode    = 1'b0;
      next_pin_output   = 1'b0;
      next_self_powered = 1'b0;
      next_pss_prev     = pss_s;
      next_oc_prev      = '1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer        <= '0;
      straps_done  <= 1'b0;
      gang_mode    <= 1'b0;
      test_mode    <= 1'b0;
      pin_output   <= 1'b0;
      self_powered <= 1'b0;
      pss_prev     <= 1'b0;
      oc_prev      <= '1;
    end else begin
      timer        <= next_timer;
      straps_done  <= next_straps_done;
      gang_mode    <= next_gang_mode;
      test_mode    <= next_test_mode;
      pin_output   <= next_pin_output;
      self_powered <= next_self_powered;
      pss_prev     <= next_pss_prev;
      oc_prev      <= next_oc_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, events and interrupt
  logic [CTRL_W-1:0]    next_ctrl;
  logic [IRQ_W-1:0]     next_irq_stat;
  logic [IRQ_W-1:0]     next_irq_mask;
  logic [IRQ_W-1:0]     events;
  logic                 next_irq;

  always_comb begin
    events                  = '0;
    events[NUM_PORTS-1:0]   = oc_prev & ~oc_s;
    events[IRQ_PSS_CHG]     = straps_done & (pss_prev ^ pss_s); // no change event before settle
    next_ctrl               = ctrl;
    next_irq_mask           = irq_mask;
    next_irq_stat           = irq_stat;
    if (wr_en && paddr == OFS_CTRL) begin
      next_ctrl = pwdata[CTRL_W-1:0];
      // eeprom role is sticky until reset
      next_ctrl[CTRL_EEPROM] = ctrl[CTRL_EEPROM] | pwdata[CTRL_EEPROM];
    end
    if (wr_en && paddr == OFS_IRQ_MASK) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
    if (wr_en && paddr == OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
    end
    // set wins over clear
    next_irq_stat = next_irq_stat | events;
    if (soft_rst) begin
      next_ctrl     = CTRL_RST;
      next_irq_mask = IRQ_RST;
      next_irq_stat = IRQ_RST;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RST;
      irq_mask <= IRQ_RST;
      irq_stat <= IRQ_RST;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      irq      <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb begin
    next_pready  = access;
    next_pslverr = access & ~addr_hit;
    next_prdata  = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_prdata[CTRL_W-1:0] = ctrl;
        end
        OFS_STATUS: begin
          next_prdata[ST_SELF_POWERED]            = self_powered;
          next_prdata[ST_GANG_MODE]               = gang_mode;
          next_prdata[ST_TEST_MODE]               = test_mode;
          next_prdata[ST_STRAPS_DONE]             = straps_done;
          next_prdata[ST_PIN_OUTPUT]              = pin_output;
          next_prdata[ST_OC_LSB +: NUM_PORTS]     = ~oc_s;
        end
        OFS_IRQ_STAT: begin
          next_prdata[IRQ_W-1:0] = irq_stat;
        end
        OFS_IRQ_MASK: begin
          next_prdata[IRQ_W-1:0] = irq_mask;
        end
        OFS_LINE: begin
          next_prdata[0] = scl_s;
          next_prdata[1] = sda_s;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic next_gang_out;
  logic next_gang_oe;
  logic next_scl_out;
  logic next_scl_oe;
  logic next_sda_out;
  logic next_sda_oe;
  logic eeprom_role;

  assign eeprom_role = ctrl[CTRL_EEPROM];

  always_comb begin
    // held as input until the output phase
    next_gang_oe = pin_output & ~soft_rst;
    if (gang_mode) begin
      next_gang_out = ctrl[CTRL_SUSPEND];
    end else begin
      next_gang_out = ~ctrl[CTRL_SUSPEND];
    end
    // open-drain eeprom clock, released in test mode or as strap
    next_scl_out = 1'b0;
    next_scl_oe  = eeprom_role & straps_done & ~test_mode & ctrl[CTRL_SCL_LOW];
    if (eeprom_role) begin
      next_sda_out = 1'b0;
      next_sda_oe  = ctrl[CTRL_SDA_LOW];
    end else begin
      next_sda_out = ~ctrl[CTRL_POWER_ON];
      next_sda_oe  = 1'b1;
    end
    if (soft_rst) begin
      next_gang_out = 1'b0;
      next_scl_oe   = 1'b0;
      next_sda_out  = 1'b1;
      next_sda_oe   = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gang_out <= 1'b0;
      gang_oe  <= 1'b0;
      scl_out  <= 1'b0;
      scl_oe   <= 1'b0;
      sda_out  <= 1'b1;
      sda_oe   <= 1'b1;
    end else begin
      gang_out <= next_gang_out;
      gang_oe  <= next_gang_oe;
      scl_out  <= next_scl_out;
      scl_oe   <= next_scl_oe;
      sda_out  <= next_sda_out;
      sda_oe   <= next_sda_oe;
    end
  end

endmodule // hsp_pin_logic
`default_nettype wire

// ---- tb/hsp_board.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsp_board (
  input  wire logic       gang_out,
  input  wire logic       gang_oe,
  input  wire logic       scl_out,
  input  wire logic       scl_oe,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  input  wire logic       gang_strap,
  input  wire logic       test_strap,
  input  wire logic [3:0] oc_fault,
  output logic            gang_in,
  output logic            scl_in,
  output logic            sda_in,
  output logic      [3:0] port_overcurrent_low
);
  // strap resistor shows through while the pin is not driven
  assign gang_in = gang_oe ? gang_out : gang_strap;
  assign scl_in = (scl_oe && !scl_out) ? 1'b0 : test_strap;
  // pull-up on the data line
  assign sda_in = sda_oe ? sda_out : 1'b1;
  // switch pulls low on fault, pad pull-up otherwise
  assign port_overcurrent_low = ~oc_fault;
endmodule // hsp_board
`default_nettype wire

// ---- tb/hsp_pin_logic_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsp_chk
  import hsp_pkg::*;
#(
  parameter int OUT_DELAY = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic ext_reset_low,
  input wire logic power_source_select,
  input wire logic gang_oe,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic self_powered,
  input wire logic test_mode,
  input wire logic irq
);
  logic [31:0] cnt, next_cnt;
  logic        ee_seen, next_ee_seen;
  logic        strap_scl, next_strap_scl;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cnt = (cnt == 32'hFFFFFFFF) ? cnt : cnt + 32'h1;
    if (!ext_reset_low) next_cnt = 32'h0;
    next_ee_seen = ext_reset_low && (ee_seen || !sda_oe);
    next_strap_scl = (cnt == 32'h0000000A) ? scl_in : strap_scl;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 32'h0;
      ee_seen <= 1'b0;
      strap_scl <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ee_seen <= next_ee_seen;
      strap_scl <= next_strap_scl;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pss_rise;
    $rose(power_source_select) ##1 power_source_select [*2];
  endsequence
  ext_rst_idle_a: assert property (!ext_reset_low [*5] |-> sda_oe && sda_out
    && !gang_oe && !scl_oe && !irq && !self_powered) else $error("soft reset state wrong");
  self_pwr_a: assert property ((power_source_select && ext_reset_low) [*6]
    |-> self_powered) else $error("self powered not shown");
  sync_delay_a: assert property (pss_rise |-> !self_powered ##1 self_powered)
    else $error("select latency wrong");
  pin_input_a: assert property (cnt > 32'h3 && cnt <= OUT_DELAY |-> !gang_oe)
    else $error("mode pin driven early");
  pin_output_a: assert property (cnt > OUT_DELAY + 8 |-> gang_oe)
    else $error("mode pin not output");
  test_strap_a: assert property (cnt == 32'h00000018 |-> test_mode == strap_scl)
    else $error("test strap not taken");
  eeprom_data_a: assert property (ee_seen |-> !sda_out)
    else $error("data line back to power enable");
  eeprom_clk_a: assert property (scl_oe |-> !scl_out && !test_mode)
    else $error("clock line driven wrongly");
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
endmodule // hsp_chk
bind hsp_pin_logic hsp_chk #(.OUT_DELAY(OUT_DELAY)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .ext_reset_low(ext_reset_low), .power_source_select(power_source_select),
  .gang_oe(gang_oe), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .self_powered(self_powered),
  .test_mode(test_mode), .irq(irq));
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hsp_pkg::*;
  localparam int OUT_DELAY = 100;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic err;} hsp_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_reset_low, pss;
  logic gang_in, gang_out, gang_oe, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic self_powered, test_mode, irq, gang_strap, test_strap, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] oc_low, oc_fault;
  int bad_count = 0;
  int n_compared = 0;
  hsp_row_t rows [6] = '{'{OFS_CTRL, 1'b0, 32'h0, 32'h0, 1'b0},
    '{OFS_LINE, 1'b0, 32'h0, 32'h2, 1'b0},
    '{OFS_IRQ_MASK, 1'b1, 32'h1F, 32'h0, 1'b0}, '{OFS_IRQ_MASK, 1'b0, 32'h0, 32'h1F, 1'b0},
    '{12'h014, 1'b0, 32'h0, 32'h0, 1'b1}, '{12'h014, 1'b1, 32'hFF, 32'h0, 1'b1}};
  hsp_pin_logic #(.OUT_DELAY(OUT_DELAY)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_reset_low(ext_reset_low),
    .power_source_select(pss), .gang_in(gang_in), .gang_out(gang_out), .gang_oe(gang_oe),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .port_overcurrent_low(oc_low), .self_powered(self_powered),
    .test_mode(test_mode), .irq(irq));
  hsp_board board (.gang_out(gang_out), .gang_oe(gang_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .gang_strap(gang_strap), .test_strap(test_strap),
    .oc_fault(oc_fault), .gang_in(gang_in), .scl_in(scl_in), .sda_in(sda_in),
    .port_overcurrent_low(oc_low));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ctrl(input logic [31:0] d);
    apb(OFS_CTRL, 1'b1, d);
    repeat (2) @(posedge pclk);
  endtask
  task wait_oe;
    int n;
    n = 0;
    while (gang_oe !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pss, test_strap, oc_fault} = '0;
    {ext_reset_low, gang_strap} = 2'b11;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({sda_oe, sda_out, gang_oe, irq}), 32'hC);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
      chk(32'(er), 32'(rows[i].err));
    end
    apb(OFS_IRQ_STAT, 1'b1, 32'h1F);
    pss <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'({self_powered, irq}), 32'h3);
    oc_fault <= 4'h4;
    repeat (6) @(posedge pclk);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h14);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk(rd & 32'hF0F, 32'h40B);
    apb(OFS_IRQ_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(OFS_IRQ_STAT, 1'b1, 32'h14);
    apb(OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ctrl(32'h1);
    chk(32'({sda_oe, sda_out}), 32'h2);
    wait_oe();
    chk(32'({gang_oe, gang_out}), 32'h2);
    ctrl(32'h3);
    chk(32'(gang_out), 32'h1);
    ctrl(32'h0C);
    chk(32'({scl_oe, scl_out, sda_oe}), 32'h4);
    ctrl(32'h15);
    chk(32'({sda_oe, sda_out}), 32'h2);
    ctrl(32'h01);
    chk(32'({sda_oe, sda_out}), 32'h0);
    {gang_strap, test_strap, ext_reset_low} <= 3'b010;
    repeat (5) @(posedge pclk);
    chk(32'({sda_oe, sda_out, gang_oe, scl_oe}), 32'hC);
    ext_reset_low <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(test_mode), 32'h1);
    wait_oe();
    chk(32'({gang_oe, gang_out}), 32'h3);
    ctrl(32'h2);
    chk(32'(gang_out), 32'h0);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
